// ==== include/cctc_map.svh ====
// Timing counts, temperature limits and reset values of the compressor cycle timer.
`ifndef CCTC_MAP_SVH
`define CCTC_MAP_SVH

// ****************************************************************
// Clock and timebase
// ****************************************************************
`define CCTC_CLK_HZ          32'h0098_9680
`define CCTC_TICK_S          32'h0000_0001
`define CCTC_TICK_CYCLES     (`CCTC_CLK_HZ * `CCTC_TICK_S)
`define CCTC_TB_W            24

// ****************************************************************
// Compressor delays, printed unit then seconds
// ****************************************************************
`define CCTC_SEC_W           10
`define CCTC_SEC_MAX         10'h3FF
`define CCTC_MIN_RUN_S_FIG   60
`define CCTC_MIN_RUN_S       10'(`CCTC_MIN_RUN_S_FIG)
`define CCTC_COOL_WAIT_MIN   3
`define CCTC_COOL_WAIT_S     10'(`CCTC_COOL_WAIT_MIN * 60)
`define CCTC_DRY_MAX_ON_MIN  10
`define CCTC_DRY_MAX_ON_S    10'(`CCTC_DRY_MAX_ON_MIN * 60)
`define CCTC_DRY_WAIT_MIN    6
`define CCTC_DRY_WAIT_S      10'(`CCTC_DRY_WAIT_MIN * 60)

// ****************************************************************
// Temperatures in whole degrees Celsius
// ****************************************************************
`define CCTC_TEMP_W          8
`define CCTC_SP_MIN          8'h10
`define CCTC_SP_MAX          8'h1E
`define CCTC_SP_RESET        8'h19
`define CCTC_COOL_ON_DELTA   8'h01

`endif

// ==== include/cctc_pkg.sv ====
// Types shared by the compressor cycle timer modules.
package cctc_pkg;

  typedef enum logic [5:0] {
    CCTC_IDLE     = 6'b00_0001,
    CCTC_COOL_OFF = 6'b00_0010,
    CCTC_COOL_ON  = 6'b00_0100,
    CCTC_DRY_WAIT = 6'b00_1000,
    CCTC_DRY_ON   = 6'b01_0000,
    CCTC_DRY_OFF  = 6'b10_0000
  } cctc_state_t;

  typedef logic [7:0] cctc_temp_t;
  typedef logic [9:0] cctc_secs_t;

endpackage

// ==== include/cctc_tick_if.sv ====
// Carrier of the one-second enable between the timebase and the controller.
interface cctc_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// ==== verilog/cctc_timebase.sv ====
// Free-running divider that makes a one-cycle enable once a second.
`include "cctc_map.svh"
module cctc_timebase #(
  parameter int TICK_CYCLES = `CCTC_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Enable out
  cctc_tick_if.src  tb
);
  import cctc_pkg::*;

  logic [`CCTC_TB_W-1:0] count;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count   <= '0;
      tb.tick <= 1'b0;
    end else if (count == `CCTC_TB_W'(TICK_CYCLES - 1)) begin
      count   <= '0;
      tb.tick <= 1'b1;
    end else begin
      count   <= count + `CCTC_TB_W'(1);
      tb.tick <= 1'b0;
    end
  end
endmodule

// ==== verilog/cctc_top.sv ====
// Compressor cycle timer for cooling and dehumidify operation of an indoor controller.
`include "cctc_map.svh"
module cctc_top #(
  parameter int TICK_CYCLES = `CCTC_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Remote control settings, asynchronous
  input  wire logic              run_req,
  input  wire logic              dry_req,
  input  wire cctc_pkg::cctc_temp_t setpoint_req,
  // Intake air sensor, asynchronous
  input  wire cctc_pkg::cctc_temp_t intake_temp,
  // Drives and status
  output logic                   comp_on,
  output logic                   odfan_on,
  output logic                   cool_active,
  output logic                   dry_active,
  output cctc_pkg::cctc_temp_t   setpoint
);
  import cctc_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // The sensor and remote words change slowly; a torn word lasts one
  // cycle and is harmless against delays of minutes.
  logic       run_m, run_s, dry_m, dry_s, dry_prev;
  cctc_temp_t sp_m, sp_s, temp_m, temp_s;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_m  <= 1'b0;
      run_s  <= 1'b0;
      dry_m  <= 1'b0;
      dry_s  <= 1'b0;
      sp_m   <= `CCTC_SP_RESET;
      sp_s   <= `CCTC_SP_RESET;
      temp_m <= 8'h00;
      temp_s <= 8'h00;
    end else begin
      run_m  <= run_req;
      run_s  <= run_m;
      dry_m  <= dry_req;
      dry_s  <= dry_m;
      sp_m   <= setpoint_req;
      sp_s   <= sp_m;
      temp_m <= intake_temp;
      temp_s <= temp_m;
    end
  end

  // ****************************************************************
  // Setpoint
  // ****************************************************************
  function automatic logic sp_valid(input cctc_temp_t t);
    return (t >= `CCTC_SP_MIN) && (t <= `CCTC_SP_MAX);
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setpoint <= `CCTC_SP_RESET;
    end else if (sp_valid(sp_s)) begin
      setpoint <= sp_s;
    end
  end

  // ****************************************************************
  // Timebase and event timer
  // ****************************************************************
  cctc_tick_if tick_bus ();

  cctc_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .clock (clock),
    .rst_n (rst_n),
    .tb    (tick_bus)
  );

  cctc_state_t state, next_state;
  logic        next_comp;
  logic        dry_first;
  logic        dry_to_cool;
  cctc_secs_t  secs;

  // Seconds since the last compressor start or stop, saturating.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      secs <= '0;
    end else if (next_comp != comp_on) begin
      secs <= '0;
    end else if (tick_bus.tick && secs != `CCTC_SEC_MAX) begin
      secs <= secs + 10'h001;
    end
  end

  // ****************************************************************
  // Compressor state machine
  // ****************************************************************
  logic want_dry, warm, reached, cold, hot, run_done;

  always_comb begin
    want_dry = dry_s && !dry_to_cool;
    warm     = temp_s > setpoint;
    reached  = temp_s >= setpoint;
    cold     = temp_s < setpoint;
    hot      = temp_s > (setpoint + `CCTC_COOL_ON_DELTA);
    run_done = secs >= `CCTC_MIN_RUN_S;
  end

  always_comb begin
    next_state = state;
    unique case (state)
      CCTC_IDLE: begin
        if (run_s) begin
          next_state = dry_s ? CCTC_DRY_WAIT : CCTC_COOL_OFF;
        end
      end
      CCTC_COOL_OFF: begin
        if (want_dry) begin
          next_state = CCTC_DRY_WAIT;
        end else if (warm && secs >= `CCTC_COOL_WAIT_S) begin
          next_state = CCTC_COOL_ON;
        end
      end
      CCTC_COOL_ON: begin
        if (run_done && (cold || want_dry)) begin
          next_state = want_dry ? CCTC_DRY_WAIT : CCTC_COOL_OFF;
        end
      end
      CCTC_DRY_WAIT: begin
        if (!want_dry) begin
          next_state = CCTC_COOL_OFF;
        end else if (reached && secs >= `CCTC_COOL_WAIT_S) begin
          next_state = CCTC_DRY_ON;
        end
      end
      CCTC_DRY_ON: begin
        if (!want_dry) begin
          next_state = CCTC_COOL_ON;
        end else if (dry_first && secs >= `CCTC_DRY_MAX_ON_S) begin
          next_state = CCTC_DRY_OFF;
        end else if (run_done && cold) begin
          next_state = CCTC_DRY_OFF;
        end
      end
      CCTC_DRY_OFF: begin
        if (!dry_s) begin
          next_state = CCTC_COOL_OFF;
        end else if (secs >= `CCTC_DRY_WAIT_S) begin
          if (reached) begin
            next_state = CCTC_DRY_ON;
          end
        end else if (secs >= `CCTC_COOL_WAIT_S && hot) begin
          next_state = CCTC_COOL_OFF;
        end
      end
      default: next_state = CCTC_IDLE;
    endcase
    // Switching the unit off stops the compressor at once.
    if (!run_s) begin
      next_state = CCTC_IDLE;
    end
    next_comp = (next_state == CCTC_COOL_ON) || (next_state == CCTC_DRY_ON);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= CCTC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The first compressor run of a dehumidify session is time bounded.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dry_first <= 1'b1;
    end else if (state == CCTC_DRY_ON && next_state == CCTC_DRY_OFF) begin
      dry_first <= 1'b0;
    end else if (!run_s || !dry_s) begin
      dry_first <= 1'b1;
    end
  end

  // A fallback to cooling holds until the user touches mode or power.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dry_prev    <= 1'b0;
      dry_to_cool <= 1'b0;
    end else begin
      dry_prev <= dry_s;
      if (state == CCTC_DRY_OFF && next_state == CCTC_COOL_OFF && dry_s) begin
        dry_to_cool <= 1'b1;
      end else if (!run_s || (dry_s != dry_prev)) begin
        dry_to_cool <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      comp_on     <= 1'b0;
      odfan_on    <= 1'b0;
      cool_active <= 1'b0;
      dry_active  <= 1'b0;
    end else begin
      comp_on     <= next_comp;
      odfan_on    <= next_comp;
      cool_active <= (next_state == CCTC_COOL_ON) || (next_state == CCTC_COOL_OFF);
      dry_active  <= (next_state == CCTC_DRY_ON) || (next_state == CCTC_DRY_OFF) ||
                     (next_state == CCTC_DRY_WAIT);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_sp_range: assert property (@(posedge clock) disable iff (!rst_n)
    (setpoint >= `CCTC_SP_MIN) && (setpoint <= `CCTC_SP_MAX))
    else $error("Setpoint left the accepted range.");

  a_sp_reject: assert property (@(posedge clock) disable iff (!rst_n)
    !sp_valid(sp_s) |=> $stable(setpoint))
    else $error("Out of range setpoint was taken.");

  a_cool_start: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(comp_on) && $past(state) == CCTC_COOL_OFF |-> $past(temp_s) > $past(setpoint))
    else $error("Cooling started while room was not warm.");

  a_cool_restart: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(comp_on) && state == CCTC_COOL_ON |-> $past(secs) >= `CCTC_COOL_WAIT_S)
    else $error("Cooling restarted before three minutes.");

  a_min_run: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(comp_on) && $past(run_s) |-> $past(secs) >= `CCTC_MIN_RUN_S)
    else $error("Compressor stopped before sixty seconds.");

  a_dry_start: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(comp_on) && $past(state) == CCTC_DRY_WAIT |-> $past(temp_s) >= $past(setpoint))
    else $error("Dehumidify started below setpoint.");

  a_dry_max_on: assert property (@(posedge clock) disable iff (!rst_n)
    state == CCTC_DRY_ON && dry_first |-> secs <= `CCTC_DRY_MAX_ON_S)
    else $error("First dehumidify run exceeded ten minutes.");

  a_dry_to_cool: assert property (@(posedge clock) disable iff (!rst_n)
    $past(state) == CCTC_DRY_OFF && state == CCTC_COOL_OFF && $past(dry_s)
    |-> $past(secs) >= `CCTC_COOL_WAIT_S && $past(hot))
    else $error("Dehumidify fell back to cooling too early.");

  a_dry_restart: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(comp_on) && $past(state) == CCTC_DRY_OFF |-> $past(secs) >= `CCTC_DRY_WAIT_S)
    else $error("Dehumidify restarted before six minutes.");

  a_fan_follow: assert property (@(posedge clock) disable iff (!rst_n)
    odfan_on == comp_on)
    else $error("Outdoor fan differs from compressor.");

  a_timer_reset: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(comp_on) |-> secs == 10'h000 ##1 secs <= 10'h001)
    else $error("Timer not restarted on compressor event.");
endmodule

// ==== sim/cctc_remote_model.sv ====
// Model of the handheld remote settings and the intake air temperature sensor.
module cctc_remote_model (
  // Clock
  input  wire logic                  clock,
  // Settings and sensor levels
  output logic                       run_req,
  output logic                       dry_req,
  output cctc_pkg::cctc_temp_t       setpoint_req,
  output cctc_pkg::cctc_temp_t       intake_temp
);
  timeunit 1ns;
  timeprecision 1ns;
  import cctc_pkg::*;

  initial begin
    run_req      = 1'b0;
    dry_req      = 1'b0;
    setpoint_req = 8'h19;
    intake_temp  = 8'h14;
  end

  // ****************************************************************
  // Level updates
  // ****************************************************************
  // Changes land on the falling edge so the controller's synchronisers never race them.
  task automatic apply(input logic run, input logic dry, input cctc_temp_t sp,
                       input cctc_temp_t temp);
    @(negedge clock);
    run_req      = run;
    dry_req      = dry;
    setpoint_req = sp;
    intake_temp  = temp;
  endtask
endmodule

// ==== sim/cctc_top_test.sv ====
// Self-checking bench of the compressor cycle timer.
module cctc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cctc_pkg::*;

  // ****************************************************************
  // Clock, reset and design
  // ****************************************************************
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       run_req;
  logic       dry_req;
  logic       comp_on;
  logic       odfan_on;
  logic       cool_active;
  logic       dry_active;
  cctc_temp_t setpoint_req;
  cctc_temp_t intake_temp;
  cctc_temp_t setpoint;
  int         err_count = 0;
  int         compares = 0;

  initial begin
    forever #50 clock = ~clock;
  end

  // Ten clocks a second keeps the six-minute waits within a few thousand cycles.
  cctc_top #(.TICK_CYCLES(10)) u_cctc_top (
    .clock        (clock),
    .rst_n        (rst_n),
    .run_req      (run_req),
    .dry_req      (dry_req),
    .setpoint_req (setpoint_req),
    .intake_temp  (intake_temp),
    .comp_on      (comp_on),
    .odfan_on     (odfan_on),
    .cool_active  (cool_active),
    .dry_active   (dry_active),
    .setpoint     (setpoint)
  );

  cctc_remote_model u_cctc_remote_model (
    .clock        (clock),
    .run_req      (run_req),
    .dry_req      (dry_req),
    .setpoint_req (setpoint_req),
    .intake_temp  (intake_temp)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic set_in(input logic run, input logic dry, input cctc_temp_t temp);
    u_cctc_remote_model.apply(run, dry, 8'h18, temp);
  endtask

  // Counts falling edges until the compressor reaches val; a miss leaves n at max.
  task automatic span(input logic val, input int max, input int lo, input int hi);
    int n;
    n = 0;
    while (comp_on !== val && n < max) begin
      @(negedge clock);
      n++;
    end
    check(32'(n >= lo && n <= hi), 32'h1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_setpoint();
    cctc_temp_t req [5] = '{8'h0F, 8'h10, 8'h1F, 8'h1E, 8'h18};
    cctc_temp_t want [5] = '{8'h19, 8'h10, 8'h10, 8'h1E, 8'h18};
    check(32'({comp_on, odfan_on, cool_active, dry_active, setpoint}), 32'h19);
    foreach (req[i]) begin
      u_cctc_remote_model.apply(1'b0, 1'b0, req[i], 8'h14);
      repeat (5) @(negedge clock);
      check(32'(setpoint), 32'(want[i]));
    end
  endtask

  task automatic t_cool();
    set_in(1'b1, 1'b0, 8'h1A);
    span(1'b1, 2100, 1740, 1800);
    check(32'({odfan_on, cool_active, dry_active}), 32'h6);
    set_in(1'b1, 1'b0, 8'h16);
    span(1'b0, 1000, 585, 620);
    check(32'(odfan_on), 32'h0);
    set_in(1'b1, 1'b0, 8'h1A);
    span(1'b1, 2500, 1785, 1820);
    set_in(1'b0, 1'b0, 8'h1A);
    span(1'b0, 20, 1, 8);
  endtask

  task automatic t_dry();
    set_in(1'b1, 1'b1, 8'h16);
    span(1'b1, 2500, 2500, 2500);
    check(32'(dry_active), 32'h1);
    set_in(1'b1, 1'b1, 8'h18);
    span(1'b1, 20, 0, 8);
    span(1'b0, 6100, 5985, 6020);
    span(1'b1, 3700, 3585, 3620);
    check(32'({cool_active, dry_active, odfan_on}), 32'h3);
    set_in(1'b1, 1'b1, 8'h16);
    span(1'b0, 700, 585, 620);
    set_in(1'b1, 1'b1, 8'h1B);
    span(1'b1, 2000, 1785, 1820);
    check(32'({cool_active, dry_active}), 32'h2);
  endtask

  // A mode change never cuts the minimum run, and dehumidify to cooling keeps the compressor on.
  task automatic t_mode();
    set_in(1'b1, 1'b0, 8'h1B);
    repeat (5) @(negedge clock);
    check(32'({comp_on, cool_active, dry_active}), 32'h6);
    set_in(1'b1, 1'b1, 8'h1B);
    span(1'b0, 700, 575, 610);
    check(32'({cool_active, dry_active}), 32'h1);
    span(1'b1, 2000, 1785, 1820);
    set_in(1'b1, 1'b0, 8'h1B);
    span(1'b0, 12, 12, 12);
    check(32'({cool_active, dry_active}), 32'h2);
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    t_setpoint();
    t_cool();
    t_dry();
    t_mode();
    summarize();
  end

  // The scenarios need about 21,000 cycles; twice that means something hung.
  initial begin
    #(40_000 * 100);
    err_count++;
    summarize();
  end
endmodule
